/* File: rtl/dpc_top.sv */
// Purpose: Per-port burst, sync byte and on-board ECC configuration
// Assumes: Datapath and channel signals on sys_clk_in; APB slave
// Notes: Status clears on read; set wins over the clear
// Behaviour
// - Each granted channel access moves exactly the burst count of words.
// - Burst count is only 4, 8, 16, 32, 64, 128 or 256 words.
// - Each port has its own burst count, used when that port transfers.
// - A whole sync byte goes ahead of both header and data fields.
// - Each port stores a sync byte from 01 to ff; zero is refused.
// - With correction on, bad data is fixed or retried early then late.
// - With correction on, per-unit fix and recovery counts are kept.
// - With correction off, no fix is done and the host is told.
// - Correction enable is held separately per port.
// - Correction counters clear to zero on reset.
// - Each counter is writable by software with any 16-bit value.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dpc_top (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  input wire logic [1:0] port_sel_in,
  input wire logic dch_gnt_in,
  input wire logic dch_ack_in,
  output logic dch_busy_out,
  output logic dch_rel_out,
  input wire logic fld_start_in,
  output logic [7:0] sync_out,
  output logic sync_vld_out,
  input wire logic rd_sync_vld_in,
  input wire logic [7:0] rd_sync_in,
  output logic fld_err_out,
  input wire logic bad_data_in,
  input wire logic fixable_in,
  input wire logic retry_done_in,
  input wire logic retry_ok_in,
  output logic fix_out,
  output logic strb_early_out,
  output logic strb_late_out,
  output logic host_ecc_out
);
  dpc_pkg::dpc_cfg_t cfg_r [dpc_pkg::NPORT];
  dpc_pkg::dpc_cfg_t cur;
  dpc_pkg::dpc_ecc_st_t st_r;
  dpc_pkg::dpc_ecc_st_t st_nxt;
  logic [dpc_pkg::ST_W-1:0] stat_r;
  logic [dpc_pkg::ST_W-1:0] mask_r;
  logic [dpc_pkg::ST_W-1:0] ev;
  logic [1:0] unit_r;
  logic [15:0] ecc_cnt [dpc_pkg::NPORT];
  logic [15:0] stb_cnt [dpc_pkg::NPORT];
  logic [31:0] rd_nxt;
  logic [8:0] sel_len;
  logic setup;
  logic acc;
  logic wr_acc;
  logic rd_clr;
  logic fix_ev;
  logic recov_ev;
  logic giveup_ev;
  logic idle;

  assign cur = cfg_r[port_sel_in];
  assign sel_len = dpc_pkg::dpc_burst_len(cur.burst);
  assign setup = psel_in && !penable_in;
  assign acc = psel_in && penable_in && pready_out;
  assign wr_acc = acc && pwrite_in && dpc_pkg::dpc_hit(paddr_in);
  assign rd_clr = acc && !pwrite_in && paddr_in == dpc_pkg::A_STAT;
  assign idle = st_r == dpc_pkg::E_IDLE;
  assign fix_ev = idle && bad_data_in && cur.ecc_en && fixable_in;
  assign recov_ev = !idle && retry_done_in && retry_ok_in;
  assign giveup_ev = st_r == dpc_pkg::E_LATE && retry_done_in && !retry_ok_in;

  // APB slave: answer in the first access cycle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !dpc_pkg::dpc_hit(paddr_in);
      if (setup) begin
        prdata_out <= rd_nxt;
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (dpc_pkg::dpc_hit(paddr_in) && !pwrite_in) begin
      unique case (paddr_in[5:4])
        2'h0: begin
          rd_nxt = 32'(cfg_r[paddr_in[3:2]].sync)
            | (32'(cfg_r[paddr_in[3:2]].burst) << dpc_pkg::CFG_BURST_LSB)
            | (32'(cfg_r[paddr_in[3:2]].ecc_en) << dpc_pkg::CFG_ECC_BIT);
        end
        2'h1: begin
          rd_nxt = paddr_in[2] ? 32'(mask_r) : 32'(stat_r);
        end
        2'h2: begin
          rd_nxt = 32'(ecc_cnt[paddr_in[3:2]]);
        end
        2'h3: begin
          rd_nxt = 32'(stb_cnt[paddr_in[3:2]]);
        end
      endcase
    end
  end

  // Per-port configuration; illegal values leave the field unchanged
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int p = 0; p < dpc_pkg::NPORT; p++) begin
        cfg_r[p].sync <= dpc_pkg::RST_SYNC;
        cfg_r[p].burst <= dpc_pkg::RST_BURST;
        cfg_r[p].ecc_en <= dpc_pkg::RST_ECC;
      end
    end else if (wr_acc && paddr_in[5:4] == 2'h0) begin
      if (pwdata_in[dpc_pkg::CFG_SYNC_LSB +: 8] != 8'h00) begin
        cfg_r[paddr_in[3:2]].sync <=
          pwdata_in[dpc_pkg::CFG_SYNC_LSB +: 8];
      end
      if (dpc_pkg::dpc_code_ok(pwdata_in[dpc_pkg::CFG_BURST_LSB +: 3])) begin
        cfg_r[paddr_in[3:2]].burst <=
          pwdata_in[dpc_pkg::CFG_BURST_LSB +: 3];
      end
      cfg_r[paddr_in[3:2]].ecc_en <=
        pwdata_in[dpc_pkg::CFG_ECC_BIT];
    end
  end

  // Sticky status, mask and interrupt
  assign ev = {dch_rel_out, recov_ev, fix_ev,
    giveup_ev || (idle && bad_data_in && !cur.ecc_en),
    rd_sync_vld_in && rd_sync_in != cur.sync};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      stat_r <= 5'h00;
      mask_r <= dpc_pkg::RST_MASK;
      irq_out <= 1'b0;
    end else begin
      // Clear only bits already returned; a late event stays
      stat_r <= (stat_r & ~(rd_clr ? prdata_out[dpc_pkg::ST_W-1:0] : 5'h00))
        | ev;
      if (wr_acc && paddr_in == dpc_pkg::A_MASK) begin
        mask_r <= pwdata_in[dpc_pkg::ST_W-1:0];
      end
      irq_out <= |(stat_r & mask_r);
    end
  end

  // Channel burst for the transferring port
  dpc_burst u_burst (
    .clk_in(sys_clk_in),
    .rst_in(reset_in),
    .start_in(dch_gnt_in),
    .len_in(sel_len),
    .ack_in(dch_ack_in),
    .busy_out(dch_busy_out),
    .rel_out(dch_rel_out)
  );

  // Sync byte out ahead of each field, compare on read
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync_out <= 8'h00;
      sync_vld_out <= 1'b0;
      fld_err_out <= 1'b0;
    end else begin
      sync_vld_out <= fld_start_in;
      if (fld_start_in) begin
        sync_out <= cur.sync;
      end
      fld_err_out <= rd_sync_vld_in && rd_sync_in != cur.sync;
    end
  end

  // On-board correction and strobe early/late retry
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dpc_pkg::E_IDLE: begin
        if (bad_data_in && cur.ecc_en && !fixable_in) begin
          st_nxt = dpc_pkg::E_EARLY;
        end
      end
      dpc_pkg::E_EARLY: begin
        if (retry_done_in) begin
          st_nxt = retry_ok_in ? dpc_pkg::E_IDLE : dpc_pkg::E_LATE;
        end
      end
      dpc_pkg::E_LATE: begin
        if (retry_done_in) begin
          st_nxt = dpc_pkg::E_IDLE;
        end
      end
      default: begin
        st_nxt = dpc_pkg::E_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_r <= dpc_pkg::E_IDLE;
      unit_r <= 2'h0;
      fix_out <= 1'b0;
      host_ecc_out <= 1'b0;
      strb_early_out <= 1'b0;
      strb_late_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (idle && bad_data_in) begin
        unit_r <= port_sel_in;
      end
      fix_out <= fix_ev;
      host_ecc_out <= giveup_ev
        || (idle && bad_data_in && !cur.ecc_en);
      strb_early_out <= st_nxt == dpc_pkg::E_EARLY;
      strb_late_out <= st_nxt == dpc_pkg::E_LATE;
    end
  end

  // Per-unit fix and recovery counters
  generate
    for (genvar u = 0; u < dpc_pkg::NPORT; u++) begin : g_unit
      localparam logic [11:0] AE = 12'(dpc_pkg::A_ECC0 + 12'(4 * u));
      localparam logic [11:0] AS = 12'(dpc_pkg::A_STB0 + 12'(4 * u));
      dpc_sat_cnt u_ecc (
        .clk_in(sys_clk_in),
        .rst_in(reset_in),
        .inc_in(fix_ev && port_sel_in == 2'(u)),
        .wr_in(wr_acc && paddr_in == AE),
        .wdata_in(pwdata_in[15:0]),
        .cnt_out(ecc_cnt[u])
      );
      dpc_sat_cnt u_stb (
        .clk_in(sys_clk_in),
        .rst_in(reset_in),
        .inc_in(recov_ev && unit_r == 2'(u)),
        .wr_in(wr_acc && paddr_in == AS),
        .wdata_in(pwdata_in[15:0]),
        .cnt_out(stb_cnt[u])
      );
    end
  endgenerate

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_code_ok;
    dpc_pkg::dpc_code_ok(cfg_r[0].burst)
      && dpc_pkg::dpc_code_ok(cfg_r[1].burst)
      && dpc_pkg::dpc_code_ok(cfg_r[2].burst)
      && dpc_pkg::dpc_code_ok(cfg_r[3].burst);
  endproperty
  a_code_ok: assert property (p_code_ok) else $error("Bad burst");

  property p_sync_nz;
    cfg_r[0].sync != 8'h00 && cfg_r[1].sync != 8'h00
      && cfg_r[2].sync != 8'h00 && cfg_r[3].sync != 8'h00;
  endproperty
  a_sync_nz: assert property (p_sync_nz) else $error("Zero sync");

  property p_port_len;
    (dch_gnt_in && !dch_busy_out) |=> u_burst.len_r == $past(sel_len);
  endproperty
  a_port_len: assert property (p_port_len) else $error("Wrong len");

  property p_sync_emit;
    fld_start_in |=> sync_vld_out && sync_out == $past(cur.sync);
  endproperty
  a_sync_emit: assert property (p_sync_emit) else $error("No sync");

  sequence s_bad_en;
    idle && bad_data_in && cur.ecc_en && !fixable_in;
  endsequence
  sequence s_retry_start;
    strb_early_out && !fix_out && !host_ecc_out;
  endsequence
  property p_retry;
    s_bad_en |=> s_retry_start;
  endproperty
  a_retry: assert property (p_retry) else $error("No retry");

  property p_no_fix;
    (idle && bad_data_in && !cur.ecc_en) |=>
      host_ecc_out && !fix_out && !strb_early_out;
  endproperty
  a_no_fix: assert property (p_no_fix) else $error("Fixed when off");

  property p_fld_err;
    (rd_sync_vld_in && rd_sync_in != cur.sync) |=>
      fld_err_out && stat_r[dpc_pkg::ST_FLDERR];
  endproperty
  a_fld_err: assert property (p_fld_err) else $error("Missed error");
endmodule : dpc_top
`default_nettype wire

/* File: inc/dpc_pkg.sv */
// Purpose: Shared constants and types for the disk port channel config
// Assumes: Four drive ports, APB register access, 32-bit data
// Notes: Byte addresses; one aligned word per register
package dpc_pkg;
  localparam int NPORT = 4;
  localparam int CW = 16;
  // Register map
  localparam logic [11:0] A_CFG0 = 12'h000;
  localparam logic [11:0] A_STAT = 12'h010;
  localparam logic [11:0] A_MASK = 12'h014;
  localparam logic [11:0] A_ECC0 = 12'h020;
  localparam logic [11:0] A_STB0 = 12'h030;
  // Config field positions
  localparam int CFG_SYNC_LSB = 0;
  localparam int CFG_BURST_LSB = 8;
  localparam int CFG_ECC_BIT = 16;
  // Reset values
  localparam logic [7:0] RST_SYNC = 8'h93;
  localparam logic [2:0] RST_BURST = 3'h2;
  localparam logic RST_ECC = 1'b1;
  localparam logic [4:0] RST_MASK = 5'h00;
  // Burst coding: words = BASE_LEN << code
  localparam logic [2:0] BURST_MAX_CODE = 3'h6;
  localparam logic [8:0] BASE_LEN = 9'h004;
  localparam logic [CW-1:0] CNT_MAX = 16'hffff;
  // Status bits
  localparam int ST_FLDERR = 0;
  localparam int ST_HOSTECC = 1;
  localparam int ST_FIX = 2;
  localparam int ST_RECOV = 3;
  localparam int ST_BDONE = 4;
  localparam int ST_W = 5;

  typedef struct packed {
    logic ecc_en;
    logic [2:0] burst;
    logic [7:0] sync;
  } dpc_cfg_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_EARLY = 2'b01,
    E_LATE = 2'b11
  } dpc_ecc_st_t;

  function automatic logic [8:0] dpc_burst_len(input logic [2:0] c);
    return 9'(BASE_LEN << c);
  endfunction : dpc_burst_len

  function automatic logic dpc_code_ok(input logic [2:0] c);
    return c <= BURST_MAX_CODE;
  endfunction : dpc_code_ok

  function automatic logic dpc_hit(input logic [11:0] a);
    if (a[11:6] != 6'h00 || a[1:0] != 2'h0)
      return 1'b0;
    if (a[5:4] == 2'h1)
      return a[3] == 1'b0;
    return 1'b1;
  endfunction : dpc_hit
endpackage : dpc_pkg

/* File: rtl/dpc_sat_cnt.sv */
// Purpose: Saturating fix/recovery counter, software writable
// Assumes: Write and increment in one cycle: write wins
// Notes: Clears on reset
`timescale 1ns/1ps
`default_nettype none
module dpc_sat_cnt (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic inc_in,
  input wire logic wr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] cnt_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_out <= 16'h0000;
    end else if (wr_in) begin
      cnt_out <= wdata_in;
    end else if (inc_in && cnt_out != dpc_pkg::CNT_MAX) begin
      cnt_out <= 16'(cnt_out + 16'h0001);
    end
  end

  property p_sat;
    @(posedge clk_in) disable iff (rst_in)
      (inc_in && !wr_in && cnt_out == 16'hffff) |=> cnt_out == 16'hffff;
  endproperty
  a_sat: assert property (p_sat) else $error("Counter wrapped");

  property p_wr;
    @(posedge clk_in) disable iff (rst_in)
      wr_in |=> cnt_out == $past(wdata_in);
  endproperty
  a_wr: assert property (p_wr) else $error("Counter write lost");
endmodule : dpc_sat_cnt
`default_nettype wire

/* File: rtl/dpc_burst.sv */
// Purpose: Counts words of one data channel access
// Assumes: Length sampled at grant and held for the access
// Notes: Release pulses one cycle after the last word
`timescale 1ns/1ps
`default_nettype none
module dpc_burst (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [8:0] len_in,
  input wire logic ack_in,
  output logic busy_out,
  output logic rel_out
);
  logic [8:0] len_r;
  logic [8:0] cnt_r;
  logic last;

  assign last = cnt_r == 9'(len_r - 9'h001);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      rel_out <= 1'b0;
      len_r <= 9'h000;
      cnt_r <= 9'h000;
    end else begin
      rel_out <= 1'b0;
      if (!busy_out && start_in) begin
        busy_out <= 1'b1;
        len_r <= len_in;
        cnt_r <= 9'h000;
      end else if (busy_out && ack_in) begin
        if (last) begin
          busy_out <= 1'b0;
          rel_out <= 1'b1;
        end else begin
          cnt_r <= 9'(cnt_r + 9'h001);
        end
      end
    end
  end

  sequence s_last_word;
    busy_out && ack_in && last;
  endsequence

  property p_rel;
    @(posedge clk_in) disable iff (rst_in)
      s_last_word |=> rel_out && !busy_out;
  endproperty
  a_rel: assert property (p_rel) else $error("Bus not released");

  property p_hold;
    @(posedge clk_in) disable iff (rst_in)
      (busy_out && !(ack_in && last)) |=> busy_out && $stable(len_r);
  endproperty
  a_hold: assert property (p_hold) else $error("Burst cut short");
endmodule : dpc_burst
`default_nettype wire

/* File: tb/dpc_chan_model.sv */
// Purpose: Data channel partner acking words of a burst
// Assumes: Acks only in cycles after ones where the controller holds the bus
// Notes: gap_in slows it to one word every other cycle
`timescale 1ns/1ps
`default_nettype none
module dpc_chan_model (
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic gap_in,
  output logic ack_out
);
  logic tog_r = 1'b0;
  logic ack_r = 1'b0;
  assign ack_out = ack_r;
  always @(posedge clk_in) begin
    tog_r <= ~tog_r;
    ack_r <= busy_in && (!gap_in || tog_r);
  end
endmodule : dpc_chan_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the port config block
// Assumes: APB master waits for pready; no random values
// Notes: Pulse outputs are counted by a monitor; tests use deltas
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [1:0] psl = 2'h0;
  logic gnt = 1'b0, gap = 1'b0, fst = 1'b0, rvld = 1'b0, bad = 1'b0;
  logic fixa = 1'b0, rdone = 1'b0, rok = 1'b0;
  logic [7:0] rsync = 8'h00;
  logic [7:0] sync;
  logic [7:0] last_sync = 8'h00;
  logic prdy, perr, irq, ack, busy, rel, svld, ferr, fix, early, late;
  logic hecc;
  int failures = 0, comparisons = 0, cyc = 0;
  int n_ack = 0, n_rel = 0, n_fix = 0, n_host = 0, n_ferr = 0;
  logic [7:0] sy [4] = '{8'h93, 8'h01, 8'hff, 8'h5a};
  logic [2:0] bc [4] = '{3'h2, 3'h0, 3'h6, 3'h1};
  logic en [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  always #4 clk = ~clk;

  dpc_top dpc_top_i (
    .sys_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .irq_out(irq), .port_sel_in(psl), .dch_gnt_in(gnt),
    .dch_ack_in(ack), .dch_busy_out(busy), .dch_rel_out(rel),
    .fld_start_in(fst), .sync_out(sync), .sync_vld_out(svld),
    .rd_sync_vld_in(rvld), .rd_sync_in(rsync), .fld_err_out(ferr),
    .bad_data_in(bad), .fixable_in(fixa), .retry_done_in(rdone),
    .retry_ok_in(rok), .fix_out(fix), .strb_early_out(early),
    .strb_late_out(late), .host_ecc_out(hecc)
  );

  dpc_chan_model dpc_chan_model_i (
    .clk_in(clk), .busy_in(busy), .gap_in(gap), .ack_out(ack)
  );

  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Pulse counters and cycle count for the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1 && ack === 1'b1) n_ack <= n_ack + 1;
    if (rel === 1'b1) n_rel <= n_rel + 1;
    if (fix === 1'b1) n_fix <= n_fix + 1;
    if (hecc === 1'b1) n_host <= n_host + 1;
    if (ferr === 1'b1) n_ferr <= n_ferr + 1;
    if (svld === 1'b1) last_sync <= sync;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0);
  endtask : wr

  function automatic logic [11:0] ofs(input int p);
    return 12'(4 * p);
  endfunction : ofs

  function automatic logic [31:0] cfgv(input logic [7:0] s,
    input logic [2:0] b, input logic e);
    return {15'h0000, e, 5'h00, b, s};
  endfunction : cfgv

  task automatic ecc_evt(input logic f);
    bad <= 1'b1;
    fixa <= f;
    step(1);
    bad <= 1'b0;
    step(4);
  endtask : ecc_evt

  task automatic retry(input logic ok);
    rdone <= 1'b1;
    rok <= ok;
    step(1);
    rdone <= 1'b0;
    step(4);
  endtask : retry

  task automatic sync_rd(input logic [7:0] b);
    rsync <= b;
    rvld <= 1'b1;
    step(1);
    rvld <= 1'b0;
    step(3);
  endtask : sync_rd

  task automatic run_tests();
    logic [31:0] r;
    logic e;
    int a0;
    int r0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      rd(ofs(p), cfgv(dpc_pkg::RST_SYNC, dpc_pkg::RST_BURST,
        dpc_pkg::RST_ECC));
      rd(dpc_pkg::A_ECC0 + ofs(p), 32'h0);
      rd(dpc_pkg::A_STB0 + ofs(p), 32'h0);
    end
    rd(dpc_pkg::A_MASK, 32'h0);
    apb(1'b0, 12'h018, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wr(ofs(p), cfgv(sy[p], bc[p], en[p]));
      rd(ofs(p), cfgv(sy[p], bc[p], en[p]));
    end
    wr(ofs(1), cfgv(8'h22, 3'h7, 1'b1));
    rd(ofs(1), cfgv(8'h22, 3'h0, 1'b1));
    wr(ofs(1), cfgv(8'h00, 3'h0, 1'b1));
    rd(ofs(1), cfgv(8'h22, 3'h0, 1'b1));
    sy[1] = 8'h22;
    $display("test config done");
    apb(1'b0, dpc_pkg::A_STAT, 32'h0, r, e);
    for (int p = 0; p < 4; p++) begin
      a0 = n_ack;
      r0 = n_rel;
      psl <= 2'(p);
      gap <= p[0];
      gnt <= 1'b1;
      step(1);
      gnt <= 1'b0;
      step(4);
      // Grant in mid-burst must not restart the count
      gnt <= 1'b1;
      step(1);
      gnt <= 1'b0;
      while (n_rel == r0) step(1);
      step(3);
      check(32'(n_ack - a0), 32'(4 << bc[p]));
      check(32'(n_rel - r0), 32'h1);
    end
    rd(dpc_pkg::A_STAT, 32'h10);
    $display("test burst done");
    for (int p = 0; p < 4; p++) begin
      psl <= 2'(p);
      fst <= 1'b1;
      step(1);
      fst <= 1'b0;
      step(3);
      check({24'h0, last_sync}, {24'h0, sy[p]});
    end
    wr(dpc_pkg::A_MASK, 32'h1);
    psl <= 2'h0;
    a0 = n_ferr;
    sync_rd(8'h93);
    sync_rd(8'h94);
    check(32'(n_ferr - a0), 32'h1);
    check({31'h0, irq}, 32'h1);
    rd(dpc_pkg::A_STAT, 32'h1);
    step(3);
    check({31'h0, irq}, 32'h0);
    $display("test sync done");
    a0 = n_fix;
    ecc_evt(1'b1);
    check(32'(n_fix - a0), 32'h1);
    rd(dpc_pkg::A_ECC0, 32'h1);
    ecc_evt(1'b0);
    check({31'h0, early}, 32'h1);
    retry(1'b1);
    check({31'h0, early}, 32'h0);
    rd(dpc_pkg::A_STB0, 32'h1);
    a0 = n_host;
    ecc_evt(1'b0);
    retry(1'b0);
    check({31'h0, late}, 32'h1);
    retry(1'b0);
    check(32'(n_host - a0), 32'h1);
    rd(dpc_pkg::A_STB0, 32'h1);
    wr(ofs(0), cfgv(8'h93, 3'h2, 1'b0));
    ecc_evt(1'b1);
    check(32'(n_host - a0), 32'h2);
    rd(dpc_pkg::A_ECC0, 32'h1);
    wr(ofs(0), cfgv(8'h93, 3'h2, 1'b1));
    rd(dpc_pkg::A_STAT, 32'h0e);
    $display("test ecc done");
    psl <= 2'h1;
    wr(dpc_pkg::A_ECC0 + ofs(1), 32'hfffe);
    ecc_evt(1'b1);
    ecc_evt(1'b1);
    rd(dpc_pkg::A_ECC0 + ofs(1), 32'hffff);
    rst <= 1'b1;
    step(3);
    rst <= 1'b0;
    rd(dpc_pkg::A_ECC0 + ofs(1), 32'h0);
    rd(dpc_pkg::A_STB0, 32'h0);
    $display("test counters done");
  endtask : run_tests

  initial begin
    fork
      run_tests();
      begin
        wait (cyc >= 20000);
        failures++;
        $display("CHECK FAILED at %0t: timeout", $time);
      end
    join_any
    close_out();
  end
endmodule : tb
`default_nettype wire
